/* File: design/fmt_flash_ctrl.sv */
// Purpose : flash mode/status and pulse timing registers, pulse sequencing
// Assumes : registers reached over the core's special-function port
// Notes   : prescalers come from the system timers as plain inputs
`timescale 1ns/1ps
module fmt_flash_ctrl
  import fmt_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire fmt_pkg::fmt_sfr_req_t sfr_req,
  input  wire logic         sfr_sel,
  output logic [7:0]        sfr_rdata,
  input  wire logic [7:0]   millisecond_prescaler,
  input  wire logic [7:0]   microsecond_prescaler,
  input  wire logic         serial_prog_mode,
  input  wire logic         prog_mode,
  input  wire logic         erase_req,
  input  wire logic         write_req,
  output logic              flash_erase_pulse,
  output logic              flash_write_pulse,
  output logic              flash_freq_ctrl_select,
  output logic              op_done
);
  // =======================================================
  // registers
  logic       page_erase_enable_q;
  logic       freq_ctrl_q;
  logic [7:0] timing_q;
  logic       wr_mode;
  logic       wr_timing;
  fmt_state_t state_q;
  logic       running;
  logic       done;
  logic       start;
  logic [4:0] steps;
  logic [7:0] prescale;
  logic [2:0] base;
  logic       busy;
  logic       erase_go;
  logic       hit_mode;
  logic       hit_timing;
  logic [16:0] len_exp_q;
  logic [16:0] len_cnt_q;

  // one select test shared by the write strobes, read mux and checks
  function automatic logic sfr_hit(input logic         sel,
                                   input fmt_sfr_req_t req,
                                   input logic [7:0]   addr);
    sfr_hit = sel && req.addr == addr;
  endfunction : sfr_hit

  assign hit_mode   = sfr_hit(sfr_sel, sfr_req, FLASH_MODE_STATUS_ADDR);
  assign hit_timing = sfr_hit(sfr_sel, sfr_req, FLASH_PULSE_TIMING_ADDR);
  assign wr_mode    = hit_mode && sfr_req.wr;
  assign wr_timing  = hit_timing && sfr_req.wr;

  always_ff @(posedge clk) begin
    if (rst) begin
      page_erase_enable_q <= FLASH_MODE_STATUS_RST[PAGE_ERASE_BIT];
      freq_ctrl_q         <= FLASH_MODE_STATUS_RST[FREQ_CTRL_BIT];
    end else if (wr_mode) begin
      page_erase_enable_q <= sfr_req.wdata[PAGE_ERASE_BIT];
      freq_ctrl_q         <= sfr_req.wdata[FREQ_CTRL_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      timing_q <= FLASH_PULSE_TIMING_RST;
    end else if (wr_timing) begin
      timing_q <= sfr_req.wdata;
    end
  end

  assign flash_freq_ctrl_select = freq_ctrl_q;

  // =======================================================
  // sequencing: an erase request only counts while erase mode is enabled
  assign erase_go = erase_req && page_erase_enable_q;
  assign start    = (state_q == FMT_IDLE) && (erase_go || write_req);

  always_comb begin
    if (erase_go) begin
      steps    = 5'h01 + {1'b0, timing_q[ERASE_LSB +: FIELD_W]};
      prescale = millisecond_prescaler;
      base     = 3'h1;
    end else begin
      steps    = 5'h01 + {1'b0, timing_q[WRITE_LSB +: FIELD_W]};
      prescale = microsecond_prescaler;
      base     = WRITE_BASE_CYCLES;
    end
  end

  fmt_pulse_timer fmt_pulse_timer_i (
    .clk      (clk),
    .rst      (rst),
    .start    (start),
    .steps    (steps),
    .prescale (prescale),
    .base     (base),
    .running  (running),
    .done     (done)
  );

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= FMT_IDLE;
    end else begin
      unique case (state_q)
        FMT_IDLE: begin
          if (erase_go) begin
            state_q <= FMT_ERASE;
          end else if (write_req) begin
            state_q <= FMT_WRITE;
          end
        end
        FMT_ERASE, FMT_WRITE: begin
          if (done) begin
            state_q <= FMT_IDLE;
          end
        end
        default: state_q <= FMT_IDLE;
      endcase
    end
  end

  assign busy              = running;
  assign flash_erase_pulse = running && state_q == FMT_ERASE;
  assign flash_write_pulse = running && state_q == FMT_WRITE;
  assign op_done           = done;

  // =======================================================
  // read data, registered; unused mode bits stay zero
  always_ff @(posedge clk) begin
    if (rst) begin
      sfr_rdata <= 8'h00;
    end else if (hit_mode) begin
      sfr_rdata <= 8'h00;
      sfr_rdata[PAGE_ERASE_BIT] <= page_erase_enable_q;
      sfr_rdata[FREQ_CTRL_BIT]  <= freq_ctrl_q;
      sfr_rdata[BUSY_BIT]       <= busy;
      sfr_rdata[SERIAL_BIT]     <= serial_prog_mode;
      sfr_rdata[PROG_BIT]       <= prog_mode || serial_prog_mode;
    end else if (hit_timing) begin
      sfr_rdata <= timing_q;
    end else begin
      sfr_rdata <= 8'h00;
    end
  end

  // =======================================================
  // checks; the length watch latches its expected count at start,
  // so a prescaler that moves mid-pulse cannot hide a reload fault
  always_ff @(posedge clk) begin
    if (rst) begin
      len_exp_q <= 17'h00000;
      len_cnt_q <= 17'h00000;
    end else if (start) begin
      len_exp_q <= 17'(steps) * (17'(prescale) + 17'h00001) * 17'(base);
      len_cnt_q <= 17'h00001;
    end else if (running && !done) begin
      len_cnt_q <= len_cnt_q + 17'h00001;
    end
  end

  a_busy_on_start: assert property (@(posedge clk) disable iff (rst)
    start |=> busy) else $error("busy missing after start");
  a_busy_until_done: assert property (@(posedge clk) disable iff (rst)
    (busy && !done) |=> busy) else $error("busy dropped early");
  a_erase_needs_en: assert property (@(posedge clk) disable iff (rst)
    $rose(flash_erase_pulse) |-> $past(page_erase_enable_q))
    else $error("erase without enable");
  a_unused_zero: assert property (@(posedge clk) disable iff (rst)
    $past(hit_mode)
    |-> (sfr_rdata[7] == 1'b0 && sfr_rdata[5] == 1'b0
         && sfr_rdata[3] == 1'b0)) else $error("unused bit set");
  a_serial_flags: assert property (@(posedge clk) disable iff (rst)
    ($past(hit_mode) && $past(serial_prog_mode))
    |-> (sfr_rdata[SERIAL_BIT] && sfr_rdata[PROG_BIT]))
    else $error("serial flags wrong");
  a_write_min_len: assert property (@(posedge clk) disable iff (rst)
    $rose(flash_write_pulse) |-> flash_write_pulse [*5])
    else $error("write pulse too short");
  a_timing_reset: assert property (@(posedge clk)
    $past(rst) |-> timing_q == FLASH_PULSE_TIMING_RST)
    else $error("timing reset wrong");
  a_done_idles: assert property (@(posedge clk) disable iff (rst)
    done |=> (!busy && state_q == FMT_IDLE))
    else $error("not idle after done");
  a_pulse_length: assert property (@(posedge clk) disable iff (rst)
    done |-> len_cnt_q == len_exp_q)
    else $error("pulse length wrong");
  a_erase_refused: assert property (@(posedge clk) disable iff (rst)
    (state_q == FMT_IDLE && erase_req && !page_erase_enable_q
     && !write_req) |=> !busy)
    else $error("erase taken while disabled");
  a_busy_read: assert property (@(posedge clk) disable iff (rst)
    $past(hit_mode) |-> sfr_rdata[BUSY_BIT] == $past(busy))
    else $error("busy flag read wrong");
  a_busy_holds_state: assert property (@(posedge clk) disable iff (rst)
    (busy && !done) |=> $stable(state_q))
    else $error("request taken while busy");
  a_pulse_onehot: assert property (@(posedge clk) disable iff (rst)
    !(flash_erase_pulse && flash_write_pulse))
    else $error("erase and write together");
  a_erase_en_write: assert property (@(posedge clk) disable iff (rst)
    $past(wr_mode)
    |-> page_erase_enable_q == $past(sfr_req.wdata[PAGE_ERASE_BIT]))
    else $error("erase enable write lost");
  a_timing_write: assert property (@(posedge clk) disable iff (rst)
    $past(wr_timing) |-> timing_q == $past(sfr_req.wdata))
    else $error("timing write lost");

endmodule : fmt_flash_ctrl

/* File: design/fmt_pulse_timer.sv */
// Purpose : counts one pulse of (steps) x (prescale+1) x (base) clocks
// Assumes : start is a one-cycle pulse while idle
// Notes   : done pulses on the last cycle of the pulse
`timescale 1ns/1ps
module fmt_pulse_timer (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       start,
  input  wire logic [4:0] steps,
  input  wire logic [7:0] prescale,
  input  wire logic [2:0] base,
  output logic            running,
  output logic            done
);
  logic [4:0] step_q;
  logic [7:0] pre_q;
  logic [2:0] base_q;
  logic [7:0] pre_ld_q;
  logic [2:0] base_ld_q;
  logic       run_q;
  logic       last;

  assign last    = run_q && step_q == 5'h01 && pre_q == 8'h00
                   && base_q == 3'h1;
  assign running = run_q;
  assign done    = last;

  always_ff @(posedge clk) begin
    if (rst) begin
      run_q  <= 1'b0;
      step_q <= 5'h00;
      pre_q  <= 8'h00;
      base_q <= 3'h0;
      pre_ld_q  <= 8'h00;
      base_ld_q <= 3'h0;
    end else if (start && !run_q) begin
      run_q  <= 1'b1;
      step_q <= steps;
      pre_q  <= prescale;
      base_q <= base;
      // reload values are held here: the caller's select falls with its
      // request, so its live prescale and base no longer fit this pulse
      pre_ld_q  <= prescale;
      base_ld_q <= base;
    end else if (run_q) begin
      if (last) begin
        run_q <= 1'b0;
      end else if (base_q != 3'h1) begin
        base_q <= base_q - 3'h1;
      end else if (pre_q != 8'h00) begin
        base_q <= base_ld_q;
        pre_q  <= pre_q - 8'h01;
      end else begin
        base_q <= base_ld_q;
        pre_q  <= pre_ld_q;
        step_q <= step_q - 5'h01;
      end
    end
  end

endmodule : fmt_pulse_timer

/* File: dv/flash_mode_and_timing_ctrl_tb.sv */
// Purpose : register and pulse timing checks
// Assumes : small prescalers keep pulses short
// Notes   : lengths are measured by the array model
`timescale 1ns/1ps
module flash_mode_and_timing_ctrl_tb;
  import fmt_pkg::*;
  logic         clk, rst, sel, ser, prog, ereq, wreq;
  logic         epls, wpls, fcs, done;
  logic [7:0]   ms, us, rdata;
  fmt_sfr_req_t req;
  int           plen, err_count, checks_done, cyc;

  always #2.5 clk = ~clk;

  fmt_flash_ctrl fmt_flash_ctrl_i (.clk(clk), .rst(rst), .sfr_req(req),
    .sfr_sel(sel), .sfr_rdata(rdata), .millisecond_prescaler(ms),
    .microsecond_prescaler(us), .serial_prog_mode(ser), .prog_mode(prog),
    .erase_req(ereq), .write_req(wreq), .flash_erase_pulse(epls),
    .flash_write_pulse(wpls), .flash_freq_ctrl_select(fcs),
    .op_done(done));
  fmt_flash_model fmt_flash_model_i (.clk(clk), .rst(rst),
    .erase_pulse(epls), .write_pulse(wpls), .pulse_len(plen));

  // ========================================
  // tasks
  task automatic chk(string what, logic [31:0] e, logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %0h seen %0h", what, e, g);
    end
  endtask : chk

  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sel <= 1'b1;
    req <= '{1'b1, a, d};
    @(posedge clk);
    sel <= 1'b0;
  endtask : sfr_wr

  task automatic sfr_rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    sel <= 1'b1;
    req <= '{1'b0, a, 8'h00};
    @(posedge clk);
    sel <= 1'b0;
    #1 chk("rdata", e, rdata);
  endtask : sfr_rd

  // busy read is skipped when b is zero; k is {erase, write}
  task automatic run_op(input logic e, input logic w, input logic [1:0] k,
                        input int len, input logic [7:0] b);
    int n = 0;
    @(posedge clk);
    ereq <= e;
    wreq <= w;
    @(posedge clk);
    ereq <= 1'b0;
    wreq <= 1'b0;
    if (b != 8'h00) sfr_rd(8'hEE, b);
    #1;
    while (done !== 1'b1 && n < 2000) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("op_done", 1, done);
    chk("pulse_kind", k, {epls, wpls});
    @(posedge clk);
    #1 chk("pulse_off", 0, epls | wpls);
    @(posedge clk);
    #1 chk("pulse_len", len, plen);
  endtask : run_op

  task automatic report_and_stop();
    if (err_count == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop

  // ========================================
  // watchdog
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_count++;
      report_and_stop();
    end
  end

  // ========================================
  // sequence
  initial begin
    clk = 0; rst = 1; sel = 0; ser = 0; prog = 0; ereq = 0; wreq = 0;
    ms = 8'h03; us = 8'h01; req = '0;
    err_count = 0; checks_done = 0; cyc = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    sfr_rd(8'hEE, 8'h00);
    sfr_rd(8'hEF, 8'hA5);
    sfr_wr(8'hEE, 8'hFF);
    sfr_rd(8'hEE, 8'h50);
    chk("freq_sel", 1, fcs);
    @(posedge clk) {ser, prog} <= 2'b11;
    sfr_rd(8'hEE, 8'h53);
    @(posedge clk) ser <= 1'b0;
    sfr_rd(8'hEE, 8'h51);
    @(posedge clk) prog <= 1'b0;
    run_op(1, 0, 2'b10, 44, 8'h54);
    sfr_rd(8'hEE, 8'h50);
    sfr_wr(8'hEF, 8'h12);
    sfr_wr(8'hEE, 8'h00);
    // erase request alone while erase mode is off must start nothing
    @(posedge clk) ereq <= 1'b1;
    @(posedge clk) ereq <= 1'b0;
    sfr_rd(8'hEE, 8'h00);
    run_op(1, 1, 2'b01, 30, 8'h04);
    run_op(0, 1, 2'b01, 30, 8'h00);
    sfr_wr(8'hEF, 8'h0F);
    sfr_rd(8'hEF, 8'h0F);
    sfr_wr(8'hEE, 8'h40);
    @(posedge clk) ms <= 8'h00;
    run_op(1, 0, 2'b10, 1, 8'h00);
    run_op(0, 1, 2'b01, 160, 8'h44);
    report_and_stop();
  end
endmodule : flash_mode_and_timing_ctrl_tb

/* File: dv/fmt_flash_model.sv */
// Purpose : flash array stand-in that measures pulse lengths
// Assumes : one pulse at a time
// Notes   : length is latched the cycle after a pulse falls
`timescale 1ns/1ps
module fmt_flash_model (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic erase_pulse,
  input  wire logic write_pulse,
  output int        pulse_len
);
  int cnt_q;
  // ========================================
  // pulse length
  // totals and ranges are kept by firmware
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q     <= 0;
      pulse_len <= 0;
    end else if (erase_pulse || write_pulse) begin
      cnt_q <= cnt_q + 1;
    end else begin
      if (cnt_q != 0) pulse_len <= cnt_q;
      cnt_q <= 0;
    end
  end
endmodule : fmt_flash_model

/* File: shared/fmt_pkg.sv */
// Purpose : shared constants and types for the flash mode and timing control
// Assumes : 8-bit special-function register port, one clock
// Notes   : offsets are the special-function addresses of the two registers
package fmt_pkg;

  localparam logic [7:0] FLASH_MODE_STATUS_ADDR  = 8'hEE;
  localparam logic [7:0] FLASH_PULSE_TIMING_ADDR = 8'hEF;
  localparam logic [7:0] FLASH_MODE_STATUS_RST   = 8'h02;
  localparam logic [7:0] FLASH_PULSE_TIMING_RST  = 8'hA5;

  // mode/status field positions
  localparam int PAGE_ERASE_BIT = 6;
  localparam int FREQ_CTRL_BIT  = 4;
  localparam int BUSY_BIT       = 2;
  localparam int SERIAL_BIT     = 1;
  localparam int PROG_BIT       = 0;

  // timing field positions
  localparam int ERASE_LSB = 4;
  localparam int WRITE_LSB = 0;
  localparam int FIELD_W   = 4;

  // write pulse base multiplier of system clock periods
  localparam logic [2:0] WRITE_BASE_CYCLES = 3'h5;

  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } fmt_sfr_req_t;

  typedef enum logic [1:0] {
    FMT_IDLE  = 2'b00,
    FMT_ERASE = 2'b01,
    FMT_WRITE = 2'b10
  } fmt_state_t;

endpackage : fmt_pkg
